/* boot_strap_pin_sequencer_tb.sv */
`timescale 1ns/1ps
module boot_strap_pin_sequencer_tb;
   typedef struct
   {
      string      name;
      logic [7:0] exp;
   } bsps_note_t;
   logic clk_sys = 0, sys_rst = 1, host_rst_n = 0, want = 0, bo33 = 0, bo18 = 0;
   logic fw = 0, eld = 0, fwref = 0, tref = 0, sense = 0, tone = 0;
   logic [4:0] cs = 5'h00;
   bsps_pkg::bsps_straps_t straps = 4'h0;
   bsps_pkg::bsps_sync_cfg_t sync_cfg = '0;
   logic rin_n, valid, sa, sb, shi, slo, bro_n, sy, sy_oe, flt_n, flt_oe, tr_o, tr_oe;
   logic sck, mosi, tsen, tcom, acc, ld_req, hold, in_reset, fw_running, xover;
   bsps_pkg::bsps_boot_src_t boot_source;
   bsps_pkg::bsps_out_mode_t out_mode;
   logic [bsps_pkg::BSPS_PWM_PINS-1:0][2:0] pin_chan;
   logic [bsps_pkg::BSPS_PWM_PINS-1:0]      pin_used;
   logic [bsps_pkg::BSPS_PROTECT_INS-1:0][bsps_pkg::BSPS_PWM_CHANS-1:0] prot;
   bsps_note_t q[$];
   bsps_note_t nt;
   logic [7:0] seen;
   logic [7:0] highs;
   logic [1:0] m;
   logic [1:0] mx;
   int num_errors = 0, checks_done = 0, cyc = 0, k;
   int seed = 32'h9744268d;
   logic [31:0] r;
   event ev_chk;

   always #2 clk_sys = ~clk_sys;

   bsps_board_model u_board
   (
      .host_rst_n(host_rst_n), .host_wr_want(want), .straps(straps),
      .brownout_reset_out_n(bro_n), .host_bus_hold(hold), .supply_sync_output(sy),
      .supply_sync_oe(sy_oe), .fault_out_n(flt_n), .fault_out_oe(flt_oe),
      .reset_in_n(rin_n), .host_wr_valid(valid), .boot_select_strap_a(sa),
      .boot_select_strap_b(sb), .output_mode_strap_hi(shi), .output_mode_strap_lo(slo)
   );

   bsps_top u_dut
   (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .reset_in_n(rin_n), .brownout_3v3(bo33),
      .brownout_1v8(bo18), .brownout_reset_out_n(bro_n), .boot_select_strap_a(sa),
      .boot_select_strap_b(sb), .output_mode_strap_hi(shi), .supply_sync_output(sy),
      .supply_sync_oe(sy_oe), .output_mode_strap_lo(slo), .fault_out_n(flt_n),
      .fault_out_oe(flt_oe), .thermal_reference_pin_i(tr_oe ? tr_o : tref),
      .thermal_reference_pin_o(tr_o), .thermal_reference_pin_oe(tr_oe),
      .thermal_sense_pin(sense), .timer_one_pin(tone), .spi_sck(sck), .spi_mosi(mosi),
      .thermal_sense(tsen), .thermal_common(tcom), .fw_started(fw),
      .eeprom_load_done(eld), .fw_thermal_ref(fwref), .chan_shutdown(cs),
      .sync_cfg(sync_cfg), .host_wr_valid(valid), .host_wr_accept(acc),
      .eeprom_load_req(ld_req), .host_bus_hold(hold), .in_reset(in_reset),
      .fw_running(fw_running), .boot_source(boot_source), .out_mode(out_mode),
      .crossover_en(xover), .pwm_pin_chan(pin_chan), .pwm_pin_used(pin_used),
      .protect_chan_mask(prot)
   );

   task automatic chk(input string n, input logic [7:0] e);
      q.push_back('{n, e});
      ->ev_chk;
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Pin usage expected for each output mode
   function automatic logic [7:0] used_of(input logic [1:0] md);
      return (md == 2'h0) ? 8'h0f : ((md == 2'h3) ? 8'hff : 8'h3f);
   endfunction

   // Channels on pins 6 and 4 for each output mode
   function automatic logic [7:0] chan_of(input logic [1:0] md);
      return (md == 2'h0) ? 8'h00 : ((md == 2'h1) ? 8'h04 : ((md == 2'h2) ? 8'h02 : 8'h1a));
   endfunction

   // Channels guarded by the second protect input for each output mode
   function automatic logic [7:0] prot1_of(input logic [1:0] md);
      return (md == 2'h2) ? 8'h04 : ((md == 2'h3) ? 8'h0c : 8'h00);
   endfunction

   initial
   begin
      forever
      begin
         @(ev_chk);
         while (q.size() > 0)
         begin
            nt = q.pop_front();
            case (nt.name)
               "in_reset": seen = 8'(in_reset);
               "boot":     seen = 8'(boot_source);
               "mode":     seen = 8'(out_mode);
               "xover":    seen = 8'(xover);
               "used":     seen = pin_used;
               "prot0":    seen = 8'(prot[0]);
               "prot1":    seen = 8'(prot[1]);
               "chan":     seen = {2'h0, pin_chan[6], pin_chan[4]};
               "load":     seen = {6'h00, ld_req, hold};
               "run":      seen = {5'h00, fw_running, sy_oe, flt_oe};
               "spi":      seen = {6'h00, sck, mosi};
               "thermal":  seen = {4'h0, tsen, tcom, tr_oe, tr_o};
               "accept":   seen = 8'(acc);
               "fault":    seen = 8'(flt_n);
               "bro":      seen = 8'(bro_n);
               "highs":    seen = highs;
               default:    seen = 8'hxx;
            endcase
            checks_done++;
            if (seen !== nt.exp)
            begin
               num_errors++;
               $display("MISMATCH %s expected %h seen %h", nt.name, nt.exp, seen);
            end
         end
      end
   end

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         num_errors++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (8) @(negedge clk_sys);
      sys_rst = 0;
      // Random offset, but every output mode still gets one pass
      r = $random(seed);
      mx = r[1:0];
      for (k = 0; k < 4; k++)
      begin
         r = $random(seed);
         m = k[1:0] ^ mx;
         {tref, sense, tone, fwref} = r[5:2];
         straps = {k[1:0], m};
         repeat (4) @(negedge clk_sys);
         chk("in_reset", 8'h01);
         host_rst_n = 1;
         repeat (8) @(negedge clk_sys);
         chk("boot", 8'(k));
         chk("mode", 8'(m));
         chk("xover", 8'(m[1]));
         chk("used", used_of(m));
         chk("prot0", 8'h03);
         chk("prot1", prot1_of(m));
         chk("chan", chan_of(m));
         chk("load", (k == 1) ? 8'h03 : 8'h00);
         chk("run", 8'h00);
         chk("spi", {6'h00, tref, sense});
         straps = ~straps;
         eld = 1;
         want = 1;
         repeat (4) @(negedge clk_sys);
         want = 0;
         chk("accept", 8'h00);
         chk("mode", 8'(m));
         chk("boot", 8'(k));
         fw = 1;
         sync_cfg = '{1'b1, 16'h0004, 16'h0001};
         repeat (6) @(negedge clk_sys);
         chk("run", 8'h07);
         chk("spi", 8'h00);
         chk("thermal", {4'h0, sense, tone, 1'b1, fwref});
         highs = 8'h00;
         repeat (8)
         begin
            @(negedge clk_sys);
            highs = highs + 8'(sy);
         end
         chk("highs", 8'h02);
         want = 1;
         @(negedge clk_sys);
         want = 0;
         chk("accept", 8'h01);
         @(negedge clk_sys);
         chk("accept", 8'h00);
         cs = r[10:6] | 5'h01;
         @(negedge clk_sys);
         chk("fault", 8'h00);
         cs = 5'h00;
         @(negedge clk_sys);
         chk("fault", 8'h01);
         if (k[0])
            bo18 = 1;
         else
            bo33 = 1;
         @(negedge clk_sys);
         chk("bro", 8'h00);
         host_rst_n = 0;
         repeat (4) @(negedge clk_sys);
         chk("in_reset", 8'h01);
         {bo33, bo18, fw, eld} = 4'h0;
         @(negedge clk_sys);
         chk("bro", 8'h01);
         $display("test boot source %0d mode %0d done", k, m);
      end
      @(negedge clk_sys);
      end_of_test();
   end
endmodule

/* bsps_board_model.sv */
`timescale 1ns/1ps
module bsps_board_model
(
   // Host and board straps
   input  wire logic                   host_rst_n,
   input  wire logic                   host_wr_want,
   input  wire bsps_pkg::bsps_straps_t straps,
   // Device pins
   input  wire logic                   brownout_reset_out_n,
   input  wire logic                   host_bus_hold,
   input  wire logic                   supply_sync_output,
   input  wire logic                   supply_sync_oe,
   input  wire logic                   fault_out_n,
   input  wire logic                   fault_out_oe,
   output      logic                   reset_in_n,
   output      logic                   host_wr_valid,
   output      logic                   boot_select_strap_a,
   output      logic                   boot_select_strap_b,
   output      logic                   output_mode_strap_hi,
   output      logic                   output_mode_strap_lo
);
   assign reset_in_n = host_rst_n & brownout_reset_out_n;
   assign host_wr_valid = host_wr_want & ~host_bus_hold;
   assign boot_select_strap_a = straps.boot_a;
   assign boot_select_strap_b = straps.boot_b;
   // Strap resistor loses to the pin driver once it is enabled
   assign output_mode_strap_hi = supply_sync_oe ? supply_sync_output : straps.mode_hi;
   assign output_mode_strap_lo = fault_out_oe ? fault_out_n : straps.mode_lo;
endmodule

/* bsps_pkg.sv */
package bsps_pkg;

   // Boot source chosen by the two boot-select straps, {strap_b, strap_a}
   typedef enum logic [1:0]
   {
      BSPS_BOOT_I2C_SLAVE = 2'h0,
      BSPS_BOOT_I2C_EEPROM = 2'h1,
      BSPS_BOOT_ROM_ONLY = 2'h2,
      BSPS_BOOT_SPI_SLAVE = 2'h3
   } bsps_boot_src_t;

   // Output configuration mode, {strap_hi, strap_lo}
   typedef enum logic [1:0]
   {
      BSPS_MODE_0 = 2'h0,
      BSPS_MODE_1 = 2'h1,
      BSPS_MODE_2 = 2'h2,
      BSPS_MODE_3 = 2'h3
   } bsps_out_mode_t;

   typedef enum
   {
      ST_HOLD,
      ST_LOAD,
      ST_INIT,
      ST_RUN
   } bsps_state_t;

   // All straps captured in one cycle
   typedef struct packed
   {
      logic           boot_b;
      logic           boot_a;
      logic           mode_hi;
      logic           mode_lo;
   } bsps_straps_t;

   // Supply sync waveform set by firmware, in system clock cycles
   typedef struct packed
   {
      logic           enable;
      logic [15:0]    period;
      logic [15:0]    high;
   } bsps_sync_cfg_t;

   localparam int           BSPS_PWM_PINS      = 8;
   localparam int           BSPS_PWM_CHANS     = 5;
   localparam int           BSPS_PROTECT_INS   = 3;
   localparam bsps_straps_t BSPS_STRAPS_RST    = 4'h0;
   localparam logic [15:0]  BSPS_SYNC_CNT_RST  = 16'h0000;
   localparam logic [15:0]  BSPS_SYNC_CNT_STEP = 16'h0001;

endpackage

/* bsps_top.sv */
`timescale 1ns/1ps
module bsps_top
#(
   parameter int BSPS_PINS = bsps_pkg::BSPS_PWM_PINS,
   parameter int BSPS_CH   = bsps_pkg::BSPS_PWM_CHANS,
   parameter int BSPS_PROT = bsps_pkg::BSPS_PROTECT_INS
)
(
   // Clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          sys_rst,
   // Reset pins and supply monitors
   input  wire logic                          reset_in_n,
   input  wire logic                          brownout_3v3,
   input  wire logic                          brownout_1v8,
   output      logic                          brownout_reset_out_n,
   // Boot straps
   input  wire logic                          boot_select_strap_a,
   input  wire logic                          boot_select_strap_b,
   // Shared config / sync pin
   input  wire logic                          output_mode_strap_hi,
   output      logic                          supply_sync_output,
   output      logic                          supply_sync_oe,
   // Shared config / error pin
   input  wire logic                          output_mode_strap_lo,
   output      logic                          fault_out_n,
   output      logic                          fault_out_oe,
   // Shared thermal / SPI pins
   input  wire logic                          thermal_reference_pin_i,
   output      logic                          thermal_reference_pin_o,
   output      logic                          thermal_reference_pin_oe,
   input  wire logic                          thermal_sense_pin,
   input  wire logic                          timer_one_pin,
   output      logic                          spi_sck,
   output      logic                          spi_mosi,
   output      logic                          thermal_sense,
   output      logic                          thermal_common,
   // Firmware and boot engine handshakes
   input  wire logic                          fw_started,
   input  wire logic                          eeprom_load_done,
   input  wire logic                          fw_thermal_ref,
   input  wire logic [BSPS_CH-1:0]            chan_shutdown,
   input  wire bsps_pkg::bsps_sync_cfg_t      sync_cfg,
   input  wire logic                          host_wr_valid,
   output      logic                          host_wr_accept,
   output      logic                          eeprom_load_req,
   output      logic                          host_bus_hold,
   output      logic                          in_reset,
   output      logic                          fw_running,
   // Latched configuration
   output      bsps_pkg::bsps_boot_src_t      boot_source,
   output      bsps_pkg::bsps_out_mode_t      out_mode,
   output      logic                          crossover_en,
   output      logic [BSPS_PINS-1:0][2:0]     pwm_pin_chan,
   output      logic [BSPS_PINS-1:0]          pwm_pin_used,
   output      logic [BSPS_PROT-1:0][BSPS_CH-1:0] protect_chan_mask
);

   // Pin-to-channel map: {used, chan[2:0]} per pin
   function automatic logic [BSPS_PINS-1:0][3:0] pin_map(input bsps_pkg::bsps_out_mode_t m);
      logic [BSPS_PINS-1:0][3:0] r;
      r = '0;
      case (m)
         bsps_pkg::BSPS_MODE_0: r = {4'h0, 4'h0, 4'h0, 4'h0, 4'h9, 4'h9, 4'h8, 4'h8};
         bsps_pkg::BSPS_MODE_1: r = {4'h0, 4'h0, 4'hc, 4'hc, 4'h9, 4'h9, 4'h8, 4'h8};
         bsps_pkg::BSPS_MODE_2: r = {4'h0, 4'h0, 4'ha, 4'ha, 4'h9, 4'h9, 4'h8, 4'h8};
         bsps_pkg::BSPS_MODE_3: r = {4'hb, 4'hb, 4'ha, 4'ha, 4'h9, 4'h9, 4'h8, 4'h8};
         default:               r = '0;
      endcase
      return r;
   endfunction

   // Protect input to powered-channel masks, per mode
   function automatic logic [BSPS_PROT-1:0][BSPS_CH-1:0] prot_map(
      input bsps_pkg::bsps_out_mode_t m);
      logic [BSPS_PROT-1:0][BSPS_CH-1:0] r;
      r = '0;
      case (m)
         bsps_pkg::BSPS_MODE_0: r = {5'h00, 5'h00, 5'h03};
         bsps_pkg::BSPS_MODE_1: r = {5'h00, 5'h00, 5'h03};
         bsps_pkg::BSPS_MODE_2: r = {5'h00, 5'h04, 5'h03};
         bsps_pkg::BSPS_MODE_3: r = {5'h00, 5'h0c, 5'h03};
         default:               r = '0;
      endcase
      return r;
   endfunction

   logic                         rin_meta;
   logic                         rin_sync;
   bsps_pkg::bsps_state_t        state;
   bsps_pkg::bsps_state_t        next_state;
   bsps_pkg::bsps_straps_t       straps;
   logic [15:0]                  sync_cnt;
   logic [BSPS_PINS-1:0][3:0]    map_now;

   // Reset input synchroniser; first stage read only by the second
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rin_meta <= 1'b0;
         rin_sync <= 1'b0;
      end
      else
      begin
         rin_meta <= reset_in_n;
         rin_sync <= rin_meta;
      end
   end

   always_comb
   begin
      next_state = state;
      if (!rin_sync)
         next_state = bsps_pkg::ST_HOLD;
      else
         case (state)
            bsps_pkg::ST_HOLD:
               next_state = ({boot_select_strap_b, boot_select_strap_a} ==
                             bsps_pkg::BSPS_BOOT_I2C_EEPROM) ? bsps_pkg::ST_LOAD
                                                             : bsps_pkg::ST_INIT;
            bsps_pkg::ST_LOAD:
               next_state = eeprom_load_done ? bsps_pkg::ST_INIT : bsps_pkg::ST_LOAD;
            bsps_pkg::ST_INIT:
               next_state = fw_started ? bsps_pkg::ST_RUN : bsps_pkg::ST_INIT;
            bsps_pkg::ST_RUN:
               next_state = bsps_pkg::ST_RUN;
            default:
               next_state = bsps_pkg::ST_HOLD;
         endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         state <= bsps_pkg::ST_HOLD;
      else
         state <= next_state;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         straps <= bsps_pkg::BSPS_STRAPS_RST;
      else if (state == bsps_pkg::ST_HOLD && rin_sync)
         straps <= {boot_select_strap_b, boot_select_strap_a,
                    output_mode_strap_hi, output_mode_strap_lo};
   end

   assign map_now = pin_map(bsps_pkg::bsps_out_mode_t'({straps.mode_hi, straps.mode_lo}));

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         boot_source       <= bsps_pkg::BSPS_BOOT_I2C_SLAVE;
         out_mode          <= bsps_pkg::BSPS_MODE_0;
         crossover_en      <= 1'b0;
         pwm_pin_chan      <= '0;
         pwm_pin_used      <= '0;
         protect_chan_mask <= '0;
      end
      else
      begin
         boot_source  <= bsps_pkg::bsps_boot_src_t'({straps.boot_b, straps.boot_a});
         out_mode     <= bsps_pkg::bsps_out_mode_t'({straps.mode_hi, straps.mode_lo});
         crossover_en <= straps.mode_hi;
         for (int i = 0; i < BSPS_PINS; i++)
         begin
            pwm_pin_chan[i] <= map_now[i][2:0];
            pwm_pin_used[i] <= map_now[i][3];
         end
         protect_chan_mask <= prot_map(
            bsps_pkg::bsps_out_mode_t'({straps.mode_hi, straps.mode_lo}));
      end
   end

   // brownout on either rail pulls reset output low
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         brownout_reset_out_n <= 1'b1;
      else
         brownout_reset_out_n <= ~(brownout_3v3 | brownout_1v8);
   end

   // host writes taken only while running
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         host_wr_accept  <= 1'b0;
         eeprom_load_req <= 1'b0;
         host_bus_hold   <= 1'b0;
         in_reset        <= 1'b1;
         fw_running      <= 1'b0;
      end
      else
      begin
         host_wr_accept  <= host_wr_valid && next_state == bsps_pkg::ST_RUN
                            && state == bsps_pkg::ST_RUN;
         eeprom_load_req <= next_state == bsps_pkg::ST_LOAD;
         host_bus_hold   <= next_state == bsps_pkg::ST_LOAD;
         in_reset        <= next_state == bsps_pkg::ST_HOLD;
         fw_running      <= next_state == bsps_pkg::ST_RUN;
      end
   end

   // firmware-timed sync waveform; counter idles outside run
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || state != bsps_pkg::ST_RUN || !sync_cfg.enable)
         sync_cnt <= bsps_pkg::BSPS_SYNC_CNT_RST;
      else if (sync_cnt + bsps_pkg::BSPS_SYNC_CNT_STEP >= sync_cfg.period)
         sync_cnt <= bsps_pkg::BSPS_SYNC_CNT_RST;
      else
         sync_cnt <= sync_cnt + bsps_pkg::BSPS_SYNC_CNT_STEP;
   end

   // shared config pins turn to outputs in run
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         supply_sync_output <= 1'b0;
         supply_sync_oe     <= 1'b0;
         fault_out_n        <= 1'b1;
         fault_out_oe       <= 1'b0;
      end
      else
      begin
         supply_sync_output <= state == bsps_pkg::ST_RUN && sync_cfg.enable
                               && sync_cnt < sync_cfg.high;
         supply_sync_oe     <= next_state == bsps_pkg::ST_RUN;
         // Follows the pin enable, so the pin never sits low while undriven
         fault_out_n        <= !(next_state == bsps_pkg::ST_RUN && |chan_shutdown);
         fault_out_oe       <= next_state == bsps_pkg::ST_RUN;
      end
   end

   // thermal pins: SPI during init, thermal use once running
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         spi_sck                  <= 1'b0;
         spi_mosi                 <= 1'b0;
         thermal_sense            <= 1'b0;
         thermal_common           <= 1'b0;
         thermal_reference_pin_o  <= 1'b0;
         thermal_reference_pin_oe <= 1'b0;
      end
      else if (state == bsps_pkg::ST_RUN)
      begin
         spi_sck                  <= 1'b0;
         spi_mosi                 <= 1'b0;
         thermal_sense            <= thermal_sense_pin;
         thermal_common           <= timer_one_pin;
         thermal_reference_pin_o  <= fw_thermal_ref;
         thermal_reference_pin_oe <= 1'b1;
      end
      else
      begin
         spi_sck                  <= thermal_reference_pin_i;
         spi_mosi                 <= thermal_sense_pin;
         thermal_sense            <= 1'b0;
         thermal_common           <= 1'b0;
         thermal_reference_pin_o  <= 1'b0;
         thermal_reference_pin_oe <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   boot_hold_a: assert property (!rin_sync |=> state == bsps_pkg::ST_HOLD)
      else $error("not held in boot while reset low");
   boot_src_a: assert property (state == bsps_pkg::ST_HOLD && rin_sync
      |=> ##1 boot_source == $past({boot_select_strap_b, boot_select_strap_a}, 2))
      else $error("boot source not from straps");
   eeprom_first_a: assert property (state == bsps_pkg::ST_LOAD |=> !host_wr_accept)
      else $error("host write taken during eeprom load");
   host_accept_a: assert property (host_wr_valid
      && state == bsps_pkg::ST_RUN && rin_sync |=> host_wr_accept)
      else $error("host write not accepted while running");
   mode_latch_a: assert property (state == bsps_pkg::ST_HOLD && rin_sync
      |=> straps.mode_hi == $past(output_mode_strap_hi)
          && straps.mode_lo == $past(output_mode_strap_lo))
      else $error("mode not captured at release");
   pins_input_a: assert property (state != bsps_pkg::ST_RUN
      && next_state != bsps_pkg::ST_RUN |=> !supply_sync_oe && !fault_out_oe)
      else $error("config pin driven before run");
   mode_hold_a: assert property (state != bsps_pkg::ST_HOLD |=> $stable(straps))
      else $error("latched mode changed");
   xover_mode_a: assert property (##2 crossover_en ==
      (out_mode == bsps_pkg::BSPS_MODE_2 || out_mode == bsps_pkg::BSPS_MODE_3))
      else $error("crossover enable wrong for mode");
   brownout_a: assert property (brownout_3v3 || brownout_1v8 |=> !brownout_reset_out_n)
      else $error("brownout did not pull reset out low");
   fault_low_a: assert property (next_state == bsps_pkg::ST_RUN && |chan_shutdown
      |=> !fault_out_n)
      else $error("fault output not low on shutdown");
   fault_idle_a: assert property (!fault_out_oe |-> fault_out_n)
      else $error("fault output low while not driven");
   therm_spi_a: assert property (state != bsps_pkg::ST_RUN |=> !thermal_reference_pin_oe)
      else $error("thermal pin driven during init");

   boot_eeprom_c: cover property (state == bsps_pkg::ST_LOAD ##[1:20] state == bsps_pkg::ST_RUN);
   boot_direct_c: cover property (state == bsps_pkg::ST_HOLD ##1 state == bsps_pkg::ST_INIT);
   fault_seen_c: cover property (fault_out_oe && !fault_out_n);
   sync_wave_c: cover property (supply_sync_output ##1 !supply_sync_output);

endmodule

/* placeholder_unused.sv */
`timescale 1ns/1ps
